// *** hdl/gipm_pkg.sv ***
// constants, tables and carrier types of the grouped io pin multiplexer
// What this block does
// - every pad is input during reset; unconfigured defaults apply after it
// - applies configured function and direction per pad
// - each pad settable input or output
// - pad count 12, 28 or 44 by variant
// - every signal in one fixed group
// - each group owns 3, 7 or 11 pads
// - signals route only to own-group pads
// - group pads take any in/out mixture
// - one selected signal per pad at most
// - one signal may drive several pads
// - disabled module frees pads to inputs
// - sync parallel extras absent on small variant
// - group 0 signal membership
// - group 1 signal membership
// - group 2 signal membership
// - group 3 signal membership
// - debug on pad 0; small variant defaults
// - largest variant unconfigured defaults
// - middle variant unconfigured defaults
package gipm_pkg;
    // ****************************************
    // variants and sizes
    // ****************************************
    localparam int VAR_SMALL = 0;
    localparam int VAR_MID = 1;
    localparam int VAR_LARGE = 2;
    localparam int MAX_PADS = 44;
    localparam int NUM_GRPS = 4;
    localparam int SEL_W = 5;
    localparam int PAD_W = 6;
    localparam int GPIO_N = 40;
    localparam int NUM_SLOTS = 25;
    // signals per group, code 0 is plain input
    localparam int GRP_CNT [NUM_GRPS] = '{24, 21, 20, 20};
    // active-low inputs idle high
    localparam logic [24:0] IN_IDLE [NUM_GRPS] =
        '{25'h0004000, 25'h0010000, 25'h0006000, 25'h003e000};
    // codes that carry a value into the core
    localparam logic [24:0] IN_MASK [NUM_GRPS] =
        '{25'h001fffe, 25'h001fffe, 25'h000fffe, 25'h003fffe};

    function automatic int pad_count(input int v);
        pad_count = (v == VAR_SMALL) ? 12 : (v == VAR_MID) ? 28 : 44;
    endfunction : pad_count

    // ****************************************
    // unconfigured defaults, code per pad
    // ****************************************
    localparam logic [4:0] DEF_SMALL [MAX_PADS] = '{
        5'h01, 5'h05, 5'h03, 5'h03, 5'h11, 5'h0f, 5'h10, 5'h0d, 5'h0f, 5'h03, 5'h13,
        5'h10, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
    localparam logic [4:0] DEF_MID [MAX_PADS] = '{
        5'h01, 5'h12, 5'h11, 5'h12, 5'h0f, 5'h03, 5'h13, 5'h10, 5'h17, 5'h14, 5'h0f,
        5'h14, 5'h11, 5'h0f, 5'h10, 5'h0d, 5'h12, 5'h10, 5'h0d, 5'h0e, 5'h13, 5'h06,
        5'h04, 5'h04, 5'h04, 5'h05, 5'h03, 5'h03, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
    localparam logic [4:0] DEF_LARGE [MAX_PADS] = '{
        5'h01, 5'h00, 5'h00, 5'h00, 5'h02, 5'h01, 5'h01, 5'h01, 5'h03, 5'h02, 5'h02,
        5'h02, 5'h14, 5'h11, 5'h0e, 5'h0f, 5'h00, 5'h00, 5'h00, 5'h00, 5'h11, 5'h0f,
        5'h10, 5'h0d, 5'h12, 5'h10, 5'h0d, 5'h0e, 5'h13, 5'h00, 5'h00, 5'h00, 5'h0f,
        5'h03, 5'h13, 5'h10, 5'h10, 5'h04, 5'h14, 5'h11, 5'h17, 5'h14, 5'h0f, 5'h14};

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic debug;
        logic gpio;
        logic parallel;
        logic parallel_sync;
        logic serial;
        logic slave0;
        logic slave1;
        logic master;
        logic pwm;
    } gipm_mod_en_s;

    typedef struct packed {
        logic debug_out;
        logic debug_oe;
        logic [GPIO_N-1:0] gpio_out;
        logic [GPIO_N-1:0] gpio_oe;
        logic [7:0] par_data_out;
        logic [7:0] par_data_oe;
        logic par_rx_full_n;
        logic par_tx_empty_n;
        logic par_clock_out;
        logic serial_txd;
        logic serial_dtr_n;
        logic serial_rts_n;
        logic serial_tx_active;
        logic [7:0] pwm;
        logic master_clock;
        logic master_mosi;
        logic [1:0] master_select_n;
        logic [1:0] slave_mosi_out;
        logic [1:0] slave_mosi_oe;
        logic [1:0] slave_miso;
    } gipm_core_out_s;

    typedef struct packed {
        logic debug_in;
        logic [GPIO_N-1:0] gpio_in;
        logic [7:0] par_data_in;
        logic par_out_enable_n;
        logic par_read_n;
        logic par_write_n;
        logic serial_rxd;
        logic serial_dsr_n;
        logic serial_dcd_n;
        logic serial_cts_n;
        logic serial_ring_indicator_n;
        logic master_miso;
        logic slave0_serial_clock;
        logic slave1_serial_clock;
        logic slave0_select_n;
        logic slave1_select_n;
        logic [1:0] slave_mosi_in;
    } gipm_core_in_s;
endpackage : gipm_pkg

// *** hdl/gipm_sync.sv ***
// two-stage synchroniser for pad inputs
`timescale 1ns/1ps
module gipm_sync
    import gipm_pkg::*;
#(
    parameter int WIDTH = MAX_PADS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ****************************************
    // two flops, first read only by second
    // ****************************************
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule : gipm_sync

// *** hdl/gipm_cfg.sv ***
// per-pad selection store with group range check
`timescale 1ns/1ps
module gipm_cfg
    import gipm_pkg::*;
#(
    parameter int NUM_PADS = MAX_PADS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cfg_write,
    input wire logic [PAD_W-1:0] cfg_pad,
    input wire logic [SEL_W-1:0] cfg_sel,
    input wire logic cfg_commit,
    input wire logic cfg_clear,
    output logic [SEL_W-1:0] sel [MAX_PADS],
    output logic loaded,
    output logic reject
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (NUM_PADS < 1 || NUM_PADS > MAX_PADS) begin : g_bad_pads
        $error("pad count beyond selection store");
    end

    // ****************************************
    // storage
    // ****************************************
    logic [SEL_W-1:0] sel_reg [MAX_PADS];
    logic [SEL_W-1:0] sel_next [MAX_PADS];
    logic loaded_reg;
    logic loaded_next;
    logic reject_reg;
    logic reject_next;
    logic ok;

    always_comb begin
        // one code per pad, so no pad can hold two signals
        ok = (int'(cfg_pad) < NUM_PADS) && (int'(cfg_sel) <= GRP_CNT[cfg_pad[1:0]]);
        sel_next = sel_reg;
        if (cfg_clear) begin
            for (int p = 0; p < MAX_PADS; p++) begin
                sel_next[p] = '0;
            end
        end
        if (cfg_write && ok) begin
            sel_next[cfg_pad] = cfg_sel;
        end
        // commit wins over a clear in the same cycle
        loaded_next = cfg_commit || (loaded_reg && !cfg_clear);
        reject_next = cfg_write && !ok;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int p = 0; p < MAX_PADS; p++) begin
                sel_reg[p] <= '0;
            end
            loaded_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            loaded_reg <= loaded_next;
            reject_reg <= reject_next;
        end
    end

    assign sel = sel_reg;
    assign loaded = loaded_reg;
    assign reject = reject_reg;
endmodule : gipm_cfg

// *** hdl/gipm_top.sv ***
// grouped io pin multiplexer: routes core signals onto group pads
`timescale 1ns/1ps
module gipm_top
    import gipm_pkg::*;
#(
    parameter int VARIANT = VAR_LARGE,
    parameter int NUM_PADS = pad_count(VARIANT)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic mux_enable,
    input gipm_mod_en_s mod_en,
    input wire logic cfg_write,
    input wire logic [PAD_W-1:0] cfg_pad,
    input wire logic [SEL_W-1:0] cfg_sel,
    input wire logic cfg_commit,
    input wire logic cfg_clear,
    output logic cfg_reject,
    output logic cfg_loaded,
    input gipm_core_out_s core_out,
    output gipm_core_in_s core_in,
    input wire logic [NUM_PADS-1:0] pad_in,
    output logic [NUM_PADS-1:0] pad_out,
    output logic [NUM_PADS-1:0] pad_oe
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (VARIANT < VAR_SMALL || VARIANT > VAR_LARGE) begin : g_bad_variant
        $error("unsupported package variant");
    end
    if (NUM_PADS != pad_count(VARIANT)) begin : g_bad_pads
        $error("pad count does not match variant");
    end

    // ****************************************
    // submodules
    // ****************************************
    logic [SEL_W-1:0] cfg_sel_q [MAX_PADS];
    logic [NUM_PADS-1:0] pad_in_sync;

    gipm_cfg #(
        .NUM_PADS(NUM_PADS)
    ) u_cfg (
        .clk(clk),
        .reset(reset),
        .cfg_write(cfg_write),
        .cfg_pad(cfg_pad),
        .cfg_sel(cfg_sel),
        .cfg_commit(cfg_commit),
        .cfg_clear(cfg_clear),
        .sel(cfg_sel_q),
        .loaded(cfg_loaded),
        .reject(cfg_reject)
    );

    gipm_sync #(
        .WIDTH(NUM_PADS)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in(pad_in),
        .sync_out(pad_in_sync)
    );

    // ****************************************
    // group slot tables
    // ****************************************
    // slot k of group g: value out, drive, module enabled
    logic go [NUM_GRPS][NUM_SLOTS];
    logic gd [NUM_GRPS][NUM_SLOTS];
    logic ge [NUM_GRPS][NUM_SLOTS];
    logic sync_ok;

    always_comb begin
        for (int g = 0; g < NUM_GRPS; g++) begin
            for (int k = 0; k < NUM_SLOTS; k++) begin
                go[g][k] = 1'b0;
                gd[g][k] = 1'b0;
                ge[g][k] = 1'b0;
            end
        end
        // extra sync parallel pins do not exist on the small package
        sync_ok = mod_en.parallel && mod_en.parallel_sync && (VARIANT != VAR_SMALL);
        // group 0
        go[0][1] = core_out.debug_out;
        gd[0][1] = core_out.debug_oe;
        ge[0][1] = mod_en.debug;
        for (int b = 0; b < 2; b++) begin
            go[0][2+b] = core_out.par_data_out[4*b];
            gd[0][2+b] = core_out.par_data_oe[4*b];
            ge[0][2+b] = mod_en.parallel;
            go[1][1+b] = core_out.par_data_out[4*b+1];
            gd[1][1+b] = core_out.par_data_oe[4*b+1];
            ge[1][1+b] = mod_en.parallel;
            go[2][1+b] = core_out.par_data_out[4*b+2];
            gd[2][1+b] = core_out.par_data_oe[4*b+2];
            ge[2][1+b] = mod_en.parallel;
            go[3][1+b] = core_out.par_data_out[4*b+3];
            gd[3][1+b] = core_out.par_data_oe[4*b+3];
            ge[3][1+b] = mod_en.parallel;
        end
        for (int i = 0; i < 10; i++) begin
            go[0][4+i] = core_out.gpio_out[4*i];
            gd[0][4+i] = core_out.gpio_oe[4*i];
            ge[0][4+i] = mod_en.gpio;
            go[1][5+i] = core_out.gpio_out[4*i+1];
            gd[1][5+i] = core_out.gpio_oe[4*i+1];
            ge[1][5+i] = mod_en.gpio;
            go[2][3+i] = core_out.gpio_out[4*i+2];
            gd[2][3+i] = core_out.gpio_oe[4*i+2];
            ge[2][3+i] = mod_en.gpio;
            go[3][3+i] = core_out.gpio_out[4*i+3];
            gd[3][3+i] = core_out.gpio_oe[4*i+3];
            ge[3][3+i] = mod_en.gpio;
        end
        ge[0][14] = sync_ok;
        ge[0][15] = mod_en.slave0;
        ge[0][16] = mod_en.slave1;
        go[0][17] = core_out.serial_txd;
        go[0][18] = core_out.serial_dtr_n;
        go[0][19] = core_out.serial_tx_active;
        go[0][20] = core_out.par_rx_full_n;
        go[0][21] = core_out.pwm[0];
        go[0][22] = core_out.pwm[4];
        go[0][23] = core_out.master_clock;
        go[0][24] = core_out.master_select_n[1];
        ge[0][17] = mod_en.serial;
        ge[0][18] = mod_en.serial;
        ge[0][19] = mod_en.serial;
        ge[0][20] = mod_en.parallel;
        ge[0][21] = mod_en.pwm;
        ge[0][22] = mod_en.pwm;
        ge[0][23] = mod_en.master;
        ge[0][24] = mod_en.master;
        // group 1
        for (int s = 0; s < 2; s++) begin
            go[1][3+s] = core_out.slave_mosi_out[s];
            gd[1][3+s] = core_out.slave_mosi_oe[s];
            go[2][19+s] = core_out.slave_miso[s];
        end
        ge[1][3] = mod_en.slave0;
        ge[1][4] = mod_en.slave1;
        ge[1][15] = mod_en.serial;
        ge[1][16] = mod_en.serial;
        go[1][17] = core_out.par_tx_empty_n;
        go[1][18] = core_out.pwm[1];
        go[1][19] = core_out.pwm[5];
        go[1][20] = core_out.master_mosi;
        go[1][21] = core_out.par_clock_out;
        ge[1][17] = mod_en.parallel;
        ge[1][18] = mod_en.pwm;
        ge[1][19] = mod_en.pwm;
        ge[1][20] = mod_en.master;
        ge[1][21] = sync_ok;
        // group 2
        ge[2][13] = mod_en.serial;
        ge[2][14] = mod_en.parallel;
        ge[2][15] = mod_en.master;
        go[2][16] = core_out.serial_rts_n;
        go[2][17] = core_out.pwm[2];
        go[2][18] = core_out.pwm[6];
        ge[2][16] = mod_en.serial;
        ge[2][17] = mod_en.pwm;
        ge[2][18] = mod_en.pwm;
        ge[2][19] = mod_en.slave0;
        ge[2][20] = mod_en.slave1;
        // group 3
        ge[3][13] = mod_en.serial;
        ge[3][14] = mod_en.serial;
        ge[3][15] = mod_en.parallel;
        ge[3][16] = mod_en.slave0;
        ge[3][17] = mod_en.slave1;
        go[3][18] = core_out.pwm[3];
        go[3][19] = core_out.pwm[7];
        go[3][20] = core_out.master_select_n[0];
        ge[3][18] = mod_en.pwm;
        ge[3][19] = mod_en.pwm;
        ge[3][20] = mod_en.master;
        // pure outputs always drive when selected
        for (int k = 17; k < NUM_SLOTS; k++) begin
            gd[0][k] = 1'b1;
        end
        for (int k = 17; k < 22; k++) begin
            gd[1][k] = 1'b1;
        end
        for (int k = 16; k < 21; k++) begin
            gd[2][k] = 1'b1;
        end
        for (int k = 18; k < 21; k++) begin
            gd[3][k] = 1'b1;
        end
    end

    // ****************************************
    // effective selection per pad
    // ****************************************
    function automatic logic [SEL_W-1:0] def_sel(input int p);
        def_sel = (VARIANT == VAR_SMALL) ? DEF_SMALL[p] :
            (VARIANT == VAR_MID) ? DEF_MID[p] : DEF_LARGE[p];
    endfunction : def_sel

    logic [SEL_W-1:0] eff [MAX_PADS];
    logic [1:0] grp;

    always_comb begin
        for (int p = 0; p < MAX_PADS; p++) begin
            grp = 2'(p % NUM_GRPS); // fixed pad group
            eff[p] = cfg_loaded ? cfg_sel_q[p] : def_sel(p);
            // disabled module or out-of-range code leaves a plain input
            if (!mux_enable || p >= NUM_PADS || int'(eff[p]) > GRP_CNT[grp] ||
                !ge[grp][eff[p]]) begin
                eff[p] = '0;
            end
        end
    end

    // ****************************************
    // pad drive, registered
    // ****************************************
    logic [NUM_PADS-1:0] out_reg;
    logic [NUM_PADS-1:0] out_next;
    logic [NUM_PADS-1:0] oe_reg;
    logic [NUM_PADS-1:0] oe_next;
    logic [1:0] pg;

    always_comb begin
        for (int p = 0; p < NUM_PADS; p++) begin
            pg = 2'(p % NUM_GRPS);
            // any mixture per group; same slot may feed many pads
            out_next[p] = go[pg][eff[p]];
            oe_next[p] = (eff[p] != '0) && gd[pg][eff[p]];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_reg <= '0;
            oe_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign pad_out = out_reg;
    assign pad_oe = oe_reg;

    // ****************************************
    // core inputs, registered
    // ****************************************
    logic gin [NUM_GRPS][NUM_SLOTS];
    logic [1:0] ig;
    gipm_core_in_s in_reg;
    gipm_core_in_s in_next;

    always_comb begin
        for (int g = 0; g < NUM_GRPS; g++) begin
            for (int k = 0; k < NUM_SLOTS; k++) begin
                gin[g][k] = IN_IDLE[g][k];
            end
        end
        // walk down so the lowest pad is the one that sticks
        for (int p = NUM_PADS - 1; p >= 0; p--) begin
            ig = 2'(p % NUM_GRPS);
            if (IN_MASK[ig][eff[p]]) begin
                gin[ig][eff[p]] = pad_in_sync[p];
            end
        end
        in_next = '0;
        in_next.debug_in = gin[0][1];
        for (int b = 0; b < 2; b++) begin
            in_next.par_data_in[4*b] = gin[0][2+b];
            in_next.par_data_in[4*b+1] = gin[1][1+b];
            in_next.par_data_in[4*b+2] = gin[2][1+b];
            in_next.par_data_in[4*b+3] = gin[3][1+b];
            in_next.slave_mosi_in[b] = gin[1][3+b];
        end
        for (int i = 0; i < 10; i++) begin
            in_next.gpio_in[4*i] = gin[0][4+i];
            in_next.gpio_in[4*i+1] = gin[1][5+i];
            in_next.gpio_in[4*i+2] = gin[2][3+i];
            in_next.gpio_in[4*i+3] = gin[3][3+i];
        end
        in_next.par_out_enable_n = gin[0][14];
        in_next.slave0_serial_clock = gin[0][15];
        in_next.slave1_serial_clock = gin[0][16];
        in_next.serial_rxd = gin[1][15];
        in_next.serial_dsr_n = gin[1][16];
        in_next.serial_dcd_n = gin[2][13];
        in_next.par_read_n = gin[2][14];
        in_next.master_miso = gin[2][15];
        in_next.serial_cts_n = gin[3][13];
        in_next.serial_ring_indicator_n = gin[3][14];
        in_next.par_write_n = gin[3][15];
        in_next.slave0_select_n = gin[3][16];
        in_next.slave1_select_n = gin[3][17];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            in_reg <= '0;
        end else begin
            in_reg <= in_next;
        end
    end

    assign core_in = in_reg;
endmodule : gipm_top

// *** tb/gipm_board.sv ***
// board-side model of the logic wired to the io pads
`timescale 1ns/1ps
module gipm_board
    import gipm_pkg::*;
#(
    parameter int NUM_PADS = MAX_PADS
) (
    input wire logic [NUM_PADS-1:0] pad_out,
    input wire logic [NUM_PADS-1:0] pad_oe,
    input wire logic [NUM_PADS-1:0] drive,
    output logic [NUM_PADS-1:0] pad_in
);
    // board backs off wherever the device drives, so no pad is fought over
    always_comb begin
        for (int p = 0; p < NUM_PADS; p++) begin
            pad_in[p] = pad_oe[p] ? pad_out[p] : drive[p];
        end
    end
endmodule : gipm_board

// *** tb/gipm_asserts.sv ***
// concurrent checks on the ports of the pin multiplexer
`timescale 1ns/1ps
module gipm_asserts
    import gipm_pkg::*;
#(
    parameter int NUM_PADS = MAX_PADS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic mux_enable,
    input gipm_mod_en_s mod_en,
    input wire logic cfg_write,
    input wire logic [PAD_W-1:0] cfg_pad,
    input wire logic [SEL_W-1:0] cfg_sel,
    input wire logic cfg_commit,
    input wire logic cfg_clear,
    input wire logic cfg_reject,
    input wire logic cfg_loaded,
    input gipm_core_out_s core_out,
    input gipm_core_in_s core_in,
    input wire logic [NUM_PADS-1:0] pad_in,
    input wire logic [NUM_PADS-1:0] pad_out,
    input wire logic [NUM_PADS-1:0] pad_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    AST_RESET_QUIET: assert property ($past(reset) |-> pad_oe == '0 && pad_out == '0)
        else $error("pads driven right after reset");
    AST_MUX_OFF: assert property (!mux_enable |=> pad_oe == '0)
        else $error("pad driven while mux off");
    AST_REJECT_PAD: assert property (cfg_write && cfg_pad >= NUM_PADS |=> cfg_reject)
        else $error("pad beyond count accepted");
    AST_REJECT_CODE: assert property (cfg_write && cfg_pad < NUM_PADS
        && cfg_sel > GRP_CNT[cfg_pad[1:0]] |=> cfg_reject)
        else $error("foreign group code accepted");
    AST_ACCEPT: assert property (cfg_write && cfg_pad < NUM_PADS
        && cfg_sel <= GRP_CNT[cfg_pad[1:0]] |=> !cfg_reject)
        else $error("legal selection refused");
    AST_LOADED: assert property (cfg_commit |=> cfg_loaded)
        else $error("commit not loaded");
    AST_CLEAR: assert property (cfg_clear && !cfg_commit |=> !cfg_loaded)
        else $error("clear left table loaded");
    AST_DEBUG_DEFAULT: assert property (mux_enable && mod_en.debug && !cfg_loaded
        && !cfg_commit && core_out.debug_oe |=> pad_oe[0] && pad_out[0] == $past(core_out.debug_out))
        else $error("debug line missing on pad 0");
    cover property (cfg_write ##1 cfg_reject);
    cover property (cfg_commit ##1 cfg_loaded);
    cover property (!mux_enable ##1 pad_oe == '0);
endmodule : gipm_asserts

bind gipm_top gipm_asserts #(.NUM_PADS(NUM_PADS)) u_asserts (.clk(clk), .reset(reset),
    .mux_enable(mux_enable), .mod_en(mod_en), .cfg_write(cfg_write), .cfg_pad(cfg_pad),
    .cfg_sel(cfg_sel), .cfg_commit(cfg_commit), .cfg_clear(cfg_clear),
    .cfg_reject(cfg_reject), .cfg_loaded(cfg_loaded), .core_out(core_out),
    .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

// *** tb/test_gipm_top.sv ***
// self-checking bench for the grouped io pin multiplexer, largest variant
`timescale 1ns/1ps
module test_gipm_top;
    import gipm_pkg::*;
    localparam int NP = 44;
    // driven pads of the unconfigured largest variant, all core oe high
    localparam logic [43:0] DEF_OE = 44'hb6611503ff1;
    typedef struct packed {
        logic [5:0] pad;
        logic [4:0] sel;
        logic rej;
        logic oe;
    } gipm_row_s;
    localparam gipm_row_s ROWS [13] = '{
        '{6'h01, 5'h11, 1'b0, 1'b1}, '{6'h05, 5'h11, 1'b0, 1'b1},
        '{6'h02, 5'h0d, 1'b0, 1'b0}, '{6'h06, 5'h0d, 1'b0, 1'b0},
        '{6'h03, 5'h14, 1'b0, 1'b1}, '{6'h00, 5'h11, 1'b0, 1'b1},
        '{6'h04, 5'h18, 1'b0, 1'b1}, '{6'h07, 5'h15, 1'b1, 1'b0},
        '{6'h08, 5'h19, 1'b1, 1'b0}, '{6'h2c, 5'h01, 1'b1, 1'b0},
        '{6'h09, 5'h16, 1'b1, 1'b0}, '{6'h0a, 5'h15, 1'b1, 1'b0},
        '{6'h0d, 5'h15, 1'b0, 1'b1}};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic mux_enable = 1'b0;
    gipm_mod_en_s mod_en = '1;
    logic cfg_write = 1'b0;
    logic [PAD_W-1:0] cfg_pad = '0;
    logic [SEL_W-1:0] cfg_sel = '0;
    logic cfg_commit = 1'b0;
    logic cfg_clear = 1'b0;
    logic cfg_reject;
    logic cfg_loaded;
    gipm_core_out_s core_out = '1;
    gipm_core_in_s core_in;
    logic [NP-1:0] drive = '0;
    logic [NP-1:0] pad_in;
    logic [NP-1:0] pad_out;
    logic [NP-1:0] pad_oe;
    int n_mismatch = 0;
    int num_checks = 0;

    always #10 clk = ~clk;

    gipm_top #(.VARIANT(VAR_LARGE)) dut (.clk(clk), .reset(reset), .mux_enable(mux_enable),
        .mod_en(mod_en), .cfg_write(cfg_write), .cfg_pad(cfg_pad), .cfg_sel(cfg_sel),
        .cfg_commit(cfg_commit), .cfg_clear(cfg_clear), .cfg_reject(cfg_reject),
        .cfg_loaded(cfg_loaded), .core_out(core_out), .core_in(core_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
    gipm_board #(.NUM_PADS(NP)) board (.pad_out(pad_out), .pad_oe(pad_oe), .drive(drive),
        .pad_in(pad_in));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic pulse(input bit clr);
        @(posedge clk);
        if (clr) begin
            cfg_clear <= 1'b1;
        end else begin
            cfg_commit <= 1'b1;
        end
        @(posedge clk);
        cfg_clear <= 1'b0;
        cfg_commit <= 1'b0;
        cyc(3);
    endtask : pulse
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [63:0] oe_x;
        cyc(9);
        chk(pad_oe, '0, "oe in reset");
        @(posedge clk);
        reset <= 1'b0;
        cyc(2);
        chk(pad_oe, '0, "oe after reset");
        @(posedge clk);
        mux_enable <= 1'b1;
        drive <= '1;
        cyc(4);
        chk(pad_oe, DEF_OE, "default directions");
        chk(pad_out & pad_oe, DEF_OE, "default levels");
        chk(core_in.serial_rxd, 1'b1, "rxd from pad 21");
        @(posedge clk);
        mod_en.serial <= 1'b0;
        cyc(2);
        chk({pad_oe[28], pad_oe[24], pad_oe[22], pad_oe[20]}, '0, "serial pads freed");
        @(posedge clk);
        mod_en.serial <= 1'b1;
        // selection rows, one write every second cycle
        foreach (ROWS[i]) begin
            @(posedge clk);
            cfg_write <= 1'b1;
            cfg_pad <= ROWS[i].pad;
            cfg_sel <= ROWS[i].sel;
            @(posedge clk);
            cfg_write <= 1'b0;
            #1;
            chk(cfg_reject, ROWS[i].rej, "reject flag");
        end
        pulse(1'b0);
        chk(cfg_loaded, 1'b1, "loaded");
        oe_x = 64'(pad_oe);
        foreach (ROWS[i]) begin
            chk(oe_x[ROWS[i].pad], ROWS[i].oe, "row direction");
        end
        @(posedge clk);
        core_out.master_select_n <= 2'b01;
        core_out.par_tx_empty_n <= 1'b0;
        mod_en.parallel_sync <= 1'b0;
        drive[2] <= 1'b0;
        cyc(4);
        chk({pad_out[5:3], pad_out[1:0]}, 5'b00101, "mirrored outputs");
        chk(core_in.serial_dcd_n, 1'b0, "lowest pad wins");
        chk({core_in.serial_cts_n, core_in.slave0_select_n, core_in.serial_rxd}, 3'b110,
            "unrouted idle");
        chk(pad_oe[13], 1'b0, "sync clock pad without sync mode");
        @(posedge clk);
        drive[2] <= 1'b1;
        drive[6] <= 1'b0;
        cyc(4);
        chk(core_in.serial_dcd_n, 1'b1, "higher pad ignored");
        @(posedge clk);
        mux_enable <= 1'b0;
        cyc(2);
        chk(pad_oe, '0, "mux off");
        @(posedge clk);
        mux_enable <= 1'b1;
        pulse(1'b1);
        chk(pad_oe, DEF_OE, "defaults after clear");
        @(posedge clk);
        reset <= 1'b1;
        cyc(3);
        chk(pad_oe, '0, "oe in mid-run reset");
        @(posedge clk);
        reset <= 1'b0;
        cyc(2);
        chk(pad_oe, DEF_OE, "defaults after mid-run reset");
        close_out();
    end

    // bound far above the fewer than one hundred cycles the sequence needs
    initial begin
        #40000;
        n_mismatch++;
        close_out();
    end
endmodule : test_gipm_top
